/* hw/ttx_device.sv */
/*
 * Transceiver device end: register set behind the processor port, detector
 * status tracking and control outputs toward the analog blocks.
 * Assumes detector levels and received code come from logic on clk.
 */
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - power-down pin high holds device in reset
// - host holds power-down 200 us before configuring
// - control at select 10; D2 picks fast
// - status at 11; idle reads D3 only
// - received digit at 01, read after detect
// - second status read during tone reads zero
// - host enables progress detect with D1 only
// - progress tone reads 1011, then 1010
// - host loads transmit digit at select 00
// - control D0 starts dual-tone transmit
// - host writes zero to end digit
// - control D3 starts progress tone output
// - D2 zero normal, one fast detection
// - detect flag set on detect, read clears
// - status D3 low while valid tone present
module ttx_device
  import ttx_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  ttx_port_if.dev port,
  input wire logic dtmf_present,
  input wire logic [3:0] dtmf_code,
  input wire logic progress_tone_present,
  input wire logic fax_tone_present,
  output logic [3:0] tx_digit_code,
  output logic dual_tone_tx_on,
  output logic progress_tone_tx_on,
  output logic fast_detect_select,
  output logic tone_detector_enable
);
  typedef struct packed {
    logic [3:0] tx_digit;
    logic [3:0] rx_digit;
    logic [3:0] control;
    logic rx_tone_absent;
    logic fax_seen;
    logic progress_seen;
    logic detect_event;
    logic [3:0] rdata;
    logic rd_valid;
  } ttx_dev_state_t;

  localparam ttx_dev_state_t TTX_DEV_RESET = '{
    tx_digit: TTX_NIBBLE_RESET,
    rx_digit: TTX_NIBBLE_RESET,
    control: TTX_NIBBLE_RESET,
    rx_tone_absent: 1'b1,
    fax_seen: 1'b0,
    progress_seen: 1'b0,
    detect_event: 1'b0,
    rdata: TTX_NIBBLE_RESET,
    rd_valid: 1'b0
  };

  ttx_dev_state_t q;
  ttx_dev_state_t d;
  logic [3:0] status_now;
  logic detect_edge;
  logic all_quiet;

  always_comb begin
    d = q;
    d.rd_valid = 1'b0;
    // detector flags follow the detectors; disabled detector pins the progress and fax flags low
    d.rx_tone_absent = ~dtmf_present;
    d.progress_seen = progress_tone_present & q.control[TTX_CTL_DETECTOR_ENABLE];
    // fax flag is forced low while a progress tone is seen
    d.fax_seen = fax_tone_present & q.control[TTX_CTL_DETECTOR_ENABLE]
                 & ~d.progress_seen;
    detect_edge = (q.rx_tone_absent & ~d.rx_tone_absent)
                  | (~q.fax_seen & d.fax_seen)
                  | (~q.progress_seen & d.progress_seen);
    all_quiet = d.rx_tone_absent & ~d.fax_seen & ~d.progress_seen;
    status_now = {q.rx_tone_absent, q.fax_seen, q.progress_seen, q.detect_event};
    // capture the code once a valid tone begins
    if (q.rx_tone_absent && !d.rx_tone_absent) begin
      d.rx_digit = dtmf_code;
    end
    if (port.wr_stb) begin
      unique case (port.addr)
        TTX_SEL_TX_DIGIT: d.tx_digit = port.wdata;
        TTX_SEL_CONTROL: d.control = port.wdata;
        TTX_SEL_RX_DIGIT, TTX_SEL_STATUS: d.control = q.control;
      endcase
    end
    if (port.rd_stb) begin
      d.rd_valid = 1'b1;
      unique case (port.addr)
        TTX_SEL_RX_DIGIT: d.rdata = q.rx_digit;
        TTX_SEL_STATUS: d.rdata = status_now;
        TTX_SEL_TX_DIGIT, TTX_SEL_CONTROL: d.rdata = TTX_NIBBLE_RESET;
      endcase
    end
    // read clears the event; a new detect in the same cycle wins
    if (port.rd_stb && port.addr == TTX_SEL_STATUS) begin
      d.detect_event = 1'b0;
    end
    if (all_quiet) begin
      d.detect_event = 1'b0;
    end
    if (detect_edge) begin
      d.detect_event = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || port.power_down_pin) begin
      q <= TTX_DEV_RESET;
    end else begin
      q <= d;
    end
  end

  assign port.rdata = q.rdata;
  assign port.rd_valid = q.rd_valid;
  assign tx_digit_code = q.tx_digit;
  assign dual_tone_tx_on = q.control[TTX_CTL_DUAL_TONE_TX_ON];
  assign progress_tone_tx_on = q.control[TTX_CTL_PROGRESS_TX_ON];
  assign fast_detect_select = q.control[TTX_CTL_FAST_DETECT];
  assign tone_detector_enable = q.control[TTX_CTL_DETECTOR_ENABLE];
endmodule
`default_nettype wire

/* hw/ttx_host.sv */
/*
 * Host end: classic wishbone slave that turns software commands into
 * processor-port accesses, sequences the power-down pin and raises an
 * interrupt on command completion and when a status read returns the detect flag.
 * Assumes the device shares clk and answers a read a cycle after rd_stb.
 */
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/1ns
`default_nettype none
module ttx_host
  import ttx_pkg::*;
#(
  parameter int PD_HOLD_CYC = TTX_PD_HOLD_CYC
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq,
  ttx_port_if.host port
);
  typedef enum logic [0:0] {TTX_IDLE, TTX_RD_WAIT} ttx_host_phase_t;

  typedef struct packed {
    ttx_host_phase_t phase;
    logic ack;
    logic [31:0] dat;
    logic pd_req;
    logic pd_pin;
    logic [TTX_PD_CNT_W-1:0] pd_cnt;
    logic refused;
    logic [3:0] rd_data;
    logic [3:0] ctl_shadow;
    logic [TTX_IRQ_BITS-1:0] irq_st;
    logic [TTX_IRQ_BITS-1:0] irq_en;
    logic irq;
    logic [1:0] addr;
    logic [3:0] wdata;
    logic wr_stb;
    logic rd_stb;
  } ttx_host_state_t;

  localparam ttx_host_state_t TTX_HOST_RESET = '{
    phase: TTX_IDLE,
    ack: 1'b0,
    dat: 32'h0000_0000,
    pd_req: 1'b1,
    pd_pin: 1'b1,
    pd_cnt: '0,
    refused: 1'b0,
    rd_data: TTX_NIBBLE_RESET,
    ctl_shadow: TTX_NIBBLE_RESET,
    irq_st: '0,
    irq_en: '0,
    irq: 1'b0,
    addr: TTX_SEL_TX_DIGIT,
    wdata: TTX_NIBBLE_RESET,
    wr_stb: 1'b0,
    rd_stb: 1'b0
  };

  localparam logic [TTX_PD_CNT_W-1:0] HOLD = TTX_PD_CNT_W'(PD_HOLD_CYC);

  ttx_host_state_t q;
  ttx_host_state_t d;
  logic bus_req;
  logic wr_lo;
  logic [TTX_IRQ_BITS-1:0] ev;
  logic [TTX_IRQ_BITS-1:0] clr;

  always_comb begin
    d = q;
    ev = '0;
    clr = '0;
    d.wr_stb = 1'b0;
    d.rd_stb = 1'b0;
    bus_req = wb_cyc_i & wb_stb_i & ~q.ack;
    wr_lo = bus_req & wb_we_i & wb_sel_i[0];
    d.ack = bus_req;
    // power-down hold: pin stays high until the hold count has elapsed
    if (q.pd_pin && q.pd_cnt != HOLD) begin
      d.pd_cnt = q.pd_cnt + 1'b1;
    end
    if (q.pd_pin && !q.pd_req && q.pd_cnt == HOLD) begin
      d.pd_pin = 1'b0;
    end
    if (wr_lo && wb_adr_i == TTX_HA_POWER) begin
      d.pd_req = wb_dat_i[0];
      if (wb_dat_i[0]) begin
        d.pd_pin = 1'b1;
        d.pd_cnt = '0;
      end
    end
    // commands are refused while the device is held in power-down
    if (wr_lo && wb_adr_i == TTX_HA_COMMAND && q.phase == TTX_IDLE) begin
      if (q.pd_pin) begin
        d.refused = 1'b1;
      end else begin
        d.refused = 1'b0;
        d.addr = wb_dat_i[TTX_CMD_SEL_LSB +: 2];
        d.wdata = wb_dat_i[TTX_CMD_DATA_LSB +: 4];
        if (wb_dat_i[TTX_CMD_READ]) begin
          d.rd_stb = 1'b1;
          d.phase = TTX_RD_WAIT;
        end else begin
          d.wr_stb = 1'b1;
          ev[TTX_IRQ_OP_DONE] = 1'b1;
          // full nibble goes out each time; shadow lets software rebuild it
          if (wb_dat_i[TTX_CMD_SEL_LSB +: 2] == TTX_SEL_CONTROL) begin
            d.ctl_shadow = wb_dat_i[TTX_CMD_DATA_LSB +: 4];
          end
        end
      end
    end
    if (q.phase == TTX_RD_WAIT && port.rd_valid) begin
      d.phase = TTX_IDLE;
      d.rd_data = port.rdata;
      ev[TTX_IRQ_OP_DONE] = 1'b1;
      // detect flag seen: software may now fetch the received digit
      if (q.addr == TTX_SEL_STATUS && port.rdata[TTX_ST_DETECT_EVENT]) begin
        ev[TTX_IRQ_DETECT] = 1'b1;
      end
    end
    if (wr_lo && wb_adr_i == TTX_HA_IRQ_ENABLE) begin
      d.irq_en = wb_dat_i[TTX_IRQ_BITS-1:0];
    end
    if (wr_lo && wb_adr_i == TTX_HA_IRQ_CLEAR) begin
      clr = wb_dat_i[TTX_IRQ_BITS-1:0];
    end
    // set wins over clear
    d.irq_st = (q.irq_st & ~clr) | ev;
    d.irq = |(d.irq_st & d.irq_en);
    d.dat = 32'h0000_0000;
    if (bus_req && !wb_we_i) begin
      unique case (wb_adr_i)
        TTX_HA_STATUS: begin
          d.dat[TTX_HS_BUSY] = q.phase != TTX_IDLE;
          d.dat[TTX_HS_PIN] = q.pd_pin;
          d.dat[TTX_HS_REFUSED] = q.refused;
          d.dat[TTX_HS_RDATA_LSB +: 4] = q.rd_data;
          d.dat[TTX_HS_SHADOW_LSB +: 4] = q.ctl_shadow;
        end
        TTX_HA_POWER: d.dat[0] = q.pd_req;
        TTX_HA_IRQ_STATUS: d.dat[TTX_IRQ_BITS-1:0] = q.irq_st;
        TTX_HA_IRQ_ENABLE: d.dat[TTX_IRQ_BITS-1:0] = q.irq_en;
        default: d.dat = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= TTX_HOST_RESET;
    end else begin
      q <= d;
    end
  end

  assign wb_dat_o = q.dat;
  assign wb_ack_o = q.ack;
  assign irq = q.irq;
  assign port.power_down_pin = q.pd_pin;
  assign port.addr = q.addr;
  assign port.wdata = q.wdata;
  assign port.wr_stb = q.wr_stb;
  assign port.rd_stb = q.rd_stb;
endmodule
`default_nettype wire

/* hw/ttx_pkg.sv */
/*
 * Shared constants for the tone transceiver port: register selects, field
 * positions, reset values, host register map and timing counts.
 * Assumes both ends run from one 125 MHz clock.
 */
package ttx_pkg;
  // register selects on the 2-bit processor port
  localparam logic [1:0] TTX_SEL_TX_DIGIT = 2'h0;
  localparam logic [1:0] TTX_SEL_RX_DIGIT = 2'h1;
  localparam logic [1:0] TTX_SEL_CONTROL = 2'h2;
  localparam logic [1:0] TTX_SEL_STATUS = 2'h3;
  // function_control fields
  localparam int TTX_CTL_DUAL_TONE_TX_ON = 0;
  localparam int TTX_CTL_DETECTOR_ENABLE = 1;
  localparam int TTX_CTL_FAST_DETECT = 2;
  localparam int TTX_CTL_PROGRESS_TX_ON = 3;
  // detector_status fields
  localparam int TTX_ST_DETECT_EVENT = 0;
  localparam int TTX_ST_PROGRESS_SEEN = 1;
  localparam int TTX_ST_FAX_SEEN = 2;
  localparam int TTX_ST_RX_TONE_ABSENT = 3;
  localparam logic [3:0] TTX_NIBBLE_RESET = 4'h0;
  // host wishbone map, byte addresses
  localparam logic [7:0] TTX_HA_COMMAND = 8'h00;
  localparam logic [7:0] TTX_HA_STATUS = 8'h04;
  localparam logic [7:0] TTX_HA_POWER = 8'h08;
  localparam logic [7:0] TTX_HA_IRQ_STATUS = 8'h0C;
  localparam logic [7:0] TTX_HA_IRQ_CLEAR = 8'h10;
  localparam logic [7:0] TTX_HA_IRQ_ENABLE = 8'h14;
  // command word fields
  localparam int TTX_CMD_DATA_LSB = 0;
  localparam int TTX_CMD_SEL_LSB = 4;
  localparam int TTX_CMD_READ = 6;
  // host status word fields
  localparam int TTX_HS_BUSY = 0;
  localparam int TTX_HS_PIN = 1;
  localparam int TTX_HS_REFUSED = 2;
  localparam int TTX_HS_RDATA_LSB = 4;
  localparam int TTX_HS_SHADOW_LSB = 8;
  // interrupt bits
  localparam int TTX_IRQ_OP_DONE = 0;
  localparam int TTX_IRQ_DETECT = 1;
  localparam int TTX_IRQ_BITS = 2;
  // timing
  localparam int TTX_CLK_MHZ = 125;
  localparam int TTX_PD_HOLD_US = 200;
  localparam int TTX_PD_HOLD_CYC = TTX_PD_HOLD_US * TTX_CLK_MHZ;
  localparam int TTX_PD_CNT_W = 16;
endpackage

/* hw/ttx_port_if.sv */
/*
 * Processor port between host and transceiver device.
 * Assumes both ends share one clock; strobes are one-cycle pulses.
 */
`timescale 1ns/1ns
`default_nettype none
interface ttx_port_if;
  logic power_down_pin;
  logic [1:0] addr;
  logic [3:0] wdata;
  logic wr_stb;
  logic rd_stb;
  logic [3:0] rdata;
  logic rd_valid;
  modport dev (
    input power_down_pin,
    input addr,
    input wdata,
    input wr_stb,
    input rd_stb,
    output rdata,
    output rd_valid
  );
  modport host (
    output power_down_pin,
    output addr,
    output wdata,
    output wr_stb,
    output rd_stb,
    input rdata,
    input rd_valid
  );
endinterface
`default_nettype wire

/* tb/test_tone_transceiver_host_sequencer.sv */
/*
 * Bench: software drives the host over wishbone, detector inputs drive the device.
 * Assumes hw/ files compiled first; hold count shortened to 8 cycles.
 */
`timescale 1ns/1ns
`default_nettype none
module test_tone_transceiver_host_sequencer;
  import ttx_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic [31:0] q, rdo;
  logic ack, irq, dton, pton, fast, den;
  logic dp = 1'b0;
  logic pp = 1'b0;
  logic fp = 1'b0;
  logic [3:0] dc = 4'h0;
  logic [3:0] txd;
  int error_cnt = 0;
  int checks_done = 0;
  ttx_port_if port();
  always #4 clk = ~clk;
  ttx_host #(.PD_HOLD_CYC(8)) ttx_host_inst(.clk(clk), .rst(rst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
    .wb_dat_o(rdo), .wb_ack_o(ack), .irq(irq), .port(port.host));
  ttx_device ttx_device_inst(.clk(clk), .rst(rst), .port(port.dev), .dtmf_present(dp),
    .dtmf_code(dc), .progress_tone_present(pp), .fax_tone_present(fp),
    .tx_digit_code(txd), .dual_tone_tx_on(dton), .progress_tone_tx_on(pton),
    .fast_detect_select(fast), .tone_detector_enable(den));
  ttx_port_asserts #(.PD_HOLD_CYC(8)) ttx_port_asserts_inst(.clk(clk), .rst(rst),
    .power_down_pin(port.power_down_pin), .addr(port.addr), .wdata(port.wdata),
    .wr_stb(port.wr_stb), .rd_stb(port.rd_stb), .rdata(port.rdata),
    .rd_valid(port.rd_valid));
  task finish_test;
    if (error_cnt == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    @(posedge clk);
    // no cycle count assumed; the watchdog ends a hung wait
    while (ack !== 1'b1) @(posedge clk);
    q = rdo;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  // leaves the final host status word in q
  task automatic cmd(input logic r, input logic [1:0] s, input logic [3:0] d);
    wb(1'b1, TTX_HA_COMMAND, {25'h0, r, s, d});
    do wb(1'b0, TTX_HA_STATUS, 32'h0); while (q[TTX_HS_BUSY] !== 1'b0);
  endtask
  task automatic sr(input logic [1:0] s);
    cmd(1'b1, s, 4'h0);
  endtask
  task t_power;
    wb(1'b0, TTX_HA_POWER, 32'h0);
    chk(q, 32'h1);
    cmd(1'b0, TTX_SEL_CONTROL, 4'h4);
    chk(q[TTX_HS_REFUSED], 1'b1);
    chk({q[TTX_HS_PIN], fast}, 2'h2);
    wb(1'b1, TTX_HA_POWER, 32'h0);
    do wb(1'b0, TTX_HA_STATUS, 32'h0); while (q[TTX_HS_PIN] !== 1'b0);
  endtask
  task t_dtmf;
    cmd(1'b0, TTX_SEL_CONTROL, 4'h4);
    chk({pton, fast, den, dton}, 4'h4);
    chk(q[11:8], 4'h4);
    sr(TTX_SEL_STATUS);
    chk(q[7:4], 4'h8);
    dp <= 1'b1;
    dc <= 4'h5;
    repeat (4) @(posedge clk);
    sr(TTX_SEL_STATUS);
    chk(q[7:4], 4'h1);
    sr(TTX_SEL_RX_DIGIT);
    chk(q[7:4], 4'h5);
    sr(TTX_SEL_STATUS);
    chk(q[7:4], 4'h0);
    dp <= 1'b0;
    repeat (4) @(posedge clk);
    sr(TTX_SEL_STATUS);
    chk(q[7:4], 4'h8);
  endtask
  task t_cpt;
    wb(1'b1, TTX_HA_IRQ_CLEAR, 32'h3);
    wb(1'b1, TTX_HA_IRQ_ENABLE, 32'h2);
    chk(irq, 1'b0);
    cmd(1'b0, TTX_SEL_CONTROL, 4'h2);
    chk({pton, fast, den, dton}, 4'h2);
    pp <= 1'b1;
    repeat (4) @(posedge clk);
    sr(TTX_SEL_STATUS);
    chk(q[7:4], 4'hB);
    chk(irq, 1'b1);
    sr(TTX_SEL_STATUS);
    chk(q[7:4], 4'hA);
    wb(1'b1, TTX_HA_IRQ_ENABLE, 32'h0);
    chk(irq, 1'b0);
    wb(1'b1, TTX_HA_IRQ_CLEAR, 32'h3);
    wb(1'b0, TTX_HA_IRQ_STATUS, 32'h0);
    chk(q, 32'h0);
    fp <= 1'b1;
    repeat (4) @(posedge clk);
    sr(TTX_SEL_STATUS);
    chk(q[7:4], 4'hA);
    pp <= 1'b0;
    repeat (4) @(posedge clk);
    sr(TTX_SEL_STATUS);
    chk(q[7:4], 4'hD);
    fp <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task t_tx;
    cmd(1'b0, TTX_SEL_TX_DIGIT, 4'h9);
    chk(txd, 4'h9);
    cmd(1'b0, TTX_SEL_CONTROL, 4'h1);
    chk({pton, fast, den, dton}, 4'h1);
    cmd(1'b0, TTX_SEL_CONTROL, 4'h0);
    chk({pton, fast, den, dton}, 4'h0);
    cmd(1'b0, TTX_SEL_CONTROL, 4'h8);
    chk({pton, fast, den, dton}, 4'h8);
    cmd(1'b0, TTX_SEL_CONTROL, 4'h0);
    chk(pton, 1'b0);
    sr(TTX_SEL_TX_DIGIT);
    chk(q[7:4], 4'h0);
    wb(1'b0, 8'h20, 32'h0);
    chk(q, 32'h0);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_power;
    t_dtmf;
    t_cpt;
    t_tx;
    finish_test;
  end
  // the whole sequence needs under two hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    finish_test;
  end
endmodule
`default_nettype wire

/* tb/ttx_port_asserts.sv */
/*
 * Port checker for the tone transceiver processor port.
 * Assumes one clock, rst synchronous active high, instanced beside the interface.
 */
`timescale 1ns/1ns
`default_nettype none
module ttx_port_asserts #(
  parameter int PD_HOLD_CYC = 8
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic power_down_pin,
  input wire logic [1:0] addr,
  input wire logic [3:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [3:0] rdata,
  input wire logic rd_valid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // saturates so a long power-down never wraps
  logic [15:0] hi_q;
  always_ff @(posedge clk) begin
    if (rst || !power_down_pin) begin
      hi_q <= 16'h0;
    end else if (hi_q != 16'hFFFF) begin
      hi_q <= hi_q + 16'h1;
    end
  end
  sequence s_rd_req;
    rd_stb && !power_down_pin;
  endsequence
  sequence s_wo_req;
    s_rd_req ##0 !addr[0];
  endsequence
  property p_rd_answer;
    s_rd_req |=> rd_valid ##0 !rd_stb [*2];
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  property p_rd_cause;
    rd_valid |-> $past(rd_stb) && !$past(power_down_pin);
  endproperty
  a_rd_cause: assert property (p_rd_cause) else $error("stray rd_valid");
  property p_wo_read;
    s_wo_req |=> rdata == 4'h0;
  endproperty
  a_wo_read: assert property (p_wo_read) else $error("write-only read not 0");
  property p_pd_quiet;
    power_down_pin |-> !wr_stb && !rd_stb;
  endproperty
  a_pd_quiet: assert property (p_pd_quiet) else $error("access in power-down");
  property p_pd_dev;
    $past(power_down_pin) |-> !rd_valid && rdata == 4'h0;
  endproperty
  a_pd_dev: assert property (p_pd_dev) else $error("device not held reset");
  property p_wr_pulse;
    wr_stb |=> !wr_stb && !rd_stb;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe too long");
  property p_rdata_hold;
    !rd_valid && !power_down_pin && !$past(power_down_pin) |-> $stable(rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("rdata moved");
  property p_pd_hold;
    $fell(power_down_pin) |-> hi_q >= 16'(PD_HOLD_CYC);
  endproperty
  a_pd_hold: assert property (p_pd_hold) else $error("power-down too short");
endmodule
`default_nettype wire
